/* File: rtl/oag_cfg.svh */
// constants for the operand address generator
// assumes a 16-bit address bus and 8-bit data bus
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
`define OAG_ADDR_W     16
`define OAG_DATA_W     8
`define OAG_ZERO_PAGE  8'h00
`define OAG_LEN_ONE    2'h1
`define OAG_LEN_TWO    2'h2
`define OAG_LEN_THREE  2'h3
`define OAG_RST_ADDR   16'h0000
`define OAG_RST_BYTE   8'h00
`endif

/* File: rtl/oag_pkg.sv */
// types shared by the operand address generator
// assumes nothing beyond the config header
package oag_pkg;
  typedef enum logic [3:0] {
    OAG_INH,
    OAG_IMM,
    OAG_DIR,
    OAG_EXT,
    OAG_IX0,
    OAG_IX1,
    OAG_IX2,
    OAG_REL,
    OAG_MUL
  } oag_mode_t;
  typedef enum logic [1:0] {
    OAG_IDLE,
    OAG_BYTE1,
    OAG_BYTE2
  } oag_state_t;
endpackage

/* File: rtl/oag_core.sv */
// operand address generator: collects operand bytes, forms effective address
// assumes the sequencer supplies the decoded mode and the fetched bytes in order
`timescale 1ns/1ps
`include "oag_cfg.svh"
module oag_core
  import oag_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire oag_mode_t   mode,
  input  wire logic        branch_taken,
  input  wire logic [15:0] pc_next,
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  idx_in,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             done,
  output logic [1:0]       instr_len,
  output logic             addr_valid,
  output logic [15:0]      eff_addr,
  output logic             imm_valid,
  output logic [7:0]       imm_data,
  output logic             pc_load,
  output logic [15:0]      pc_target,
  output logic             mul_valid,
  output logic [7:0]       acc_out,
  output logic [7:0]       idx_out,
  output logic             busy
);
  // ************************************************************
  // sequencing
  // ************************************************************
  oag_state_t  state_q;
  oag_mode_t   mode_q;
  logic [7:0]  first_q;
  logic [7:0]  idx_q;
  logic        taken_q;
  logic [15:0] pc_q;
  logic        finish;
  logic [15:0] ea_d;
  logic [15:0] tgt_d;
  logic        one_byte;

  // modes with no operand bytes finish on the start cycle
  assign one_byte = (mode == OAG_INH) || (mode == OAG_IX0) || (mode == OAG_MUL);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= OAG_IDLE;
      mode_q  <= OAG_INH;
      first_q <= `OAG_RST_BYTE;
      idx_q   <= `OAG_RST_BYTE;
      taken_q <= 1'b0;
      pc_q    <= `OAG_RST_ADDR;
    end else begin
      case (state_q)
        OAG_IDLE: begin
          if (start && !one_byte) begin
            state_q <= OAG_BYTE1;
            mode_q  <= mode;
            idx_q   <= idx_in;
            taken_q <= branch_taken;
            pc_q    <= pc_next;
          end
        end
        OAG_BYTE1: begin
          if (byte_valid) begin
            first_q <= byte_data;
            // three-byte forms need a second operand byte
            if (mode_q == OAG_EXT || mode_q == OAG_IX2) begin
              state_q <= OAG_BYTE2;
            end else begin
              state_q <= OAG_IDLE;
            end
          end
        end
        OAG_BYTE2: begin
          if (byte_valid) begin
            state_q <= OAG_IDLE;
          end
        end
        default: begin
          state_q <= OAG_IDLE;
        end
      endcase
    end
  end

  assign finish = (state_q == OAG_BYTE2 && byte_valid) ||
                  (state_q == OAG_BYTE1 && byte_valid &&
                   mode_q != OAG_EXT && mode_q != OAG_IX2);

  // ************************************************************
  // address arithmetic
  // ************************************************************
  always_comb begin
    ea_d  = `OAG_RST_ADDR;
    tgt_d = pc_q;
    case (mode_q)
      OAG_DIR: ea_d = {`OAG_ZERO_PAGE, byte_data};
      OAG_EXT: ea_d = {first_q, byte_data};
      OAG_IX1: ea_d = {8'h00, idx_q} + {8'h00, byte_data};
      OAG_IX2: ea_d = {first_q, byte_data} + {8'h00, idx_q};
      // only branches reach here; pc_q already points past the branch
      OAG_REL: tgt_d = taken_q ? pc_q + {{8{byte_data[7]}}, byte_data} : pc_q;
      default: ea_d = `OAG_RST_ADDR;
    endcase
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done       <= 1'b0;
      instr_len  <= `OAG_LEN_ONE;
      addr_valid <= 1'b0;
      eff_addr   <= `OAG_RST_ADDR;
      imm_valid  <= 1'b0;
      imm_data   <= `OAG_RST_BYTE;
      pc_load    <= 1'b0;
      pc_target  <= `OAG_RST_ADDR;
    end else begin
      done       <= 1'b0;
      addr_valid <= 1'b0;
      imm_valid  <= 1'b0;
      pc_load    <= 1'b0;
      if (state_q == OAG_IDLE && start && one_byte) begin
        done      <= 1'b1;
        instr_len <= `OAG_LEN_ONE;
        if (mode == OAG_IX0) begin
          addr_valid <= 1'b1;
          eff_addr   <= {`OAG_ZERO_PAGE, idx_in};
        end
      end else if (finish) begin
        done <= 1'b1;
        case (mode_q)
          OAG_IMM: begin
            instr_len <= `OAG_LEN_TWO;
            imm_valid <= 1'b1;
            imm_data  <= byte_data;
          end
          OAG_REL: begin
            instr_len <= `OAG_LEN_TWO;
            pc_load   <= 1'b1;
            pc_target <= tgt_d;
          end
          OAG_EXT, OAG_IX2: begin
            instr_len  <= `OAG_LEN_THREE;
            addr_valid <= 1'b1;
            eff_addr   <= ea_d;
          end
          default: begin
            instr_len  <= `OAG_LEN_TWO;
            addr_valid <= 1'b1;
            eff_addr   <= ea_d;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // unsigned multiply
  // ************************************************************
  logic [15:0] prod;
  assign prod = {8'h00, acc_in} * {8'h00, idx_in};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mul_valid <= 1'b0;
      acc_out   <= `OAG_RST_BYTE;
      idx_out   <= `OAG_RST_BYTE;
    end else begin
      mul_valid <= start && state_q == OAG_IDLE && mode == OAG_MUL;
      if (start && state_q == OAG_IDLE && mode == OAG_MUL) begin
        idx_out <= prod[15:8];
        acc_out <= prod[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_q == OAG_IDLE) ? (start && !one_byte) : !finish;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_mul_result: assert property (@(posedge clock) disable iff (sys_rst)
    (start && state_q == OAG_IDLE && mode == OAG_MUL) |=>
    ({idx_out, acc_out} == $past(acc_in) * $past(idx_in)) && mul_valid)
    else $error("multiply result misplaced");
  a_inh_len: assert property (@(posedge clock) disable iff (sys_rst)
    (start && state_q == OAG_IDLE && mode == OAG_INH) |=>
    done && instr_len == 2'h1 && !addr_valid)
    else $error("inherent length wrong");
  a_ix0_addr: assert property (@(posedge clock) disable iff (sys_rst)
    (start && state_q == OAG_IDLE && mode == OAG_IX0) |=>
    addr_valid && eff_addr == {8'h00, $past(idx_in)})
    else $error("indexed no offset address wrong");
  a_imm_data: assert property (@(posedge clock) disable iff (sys_rst)
    (finish && mode_q == OAG_IMM) |=> imm_valid && imm_data == $past(byte_data)
    && instr_len == 2'h2)
    else $error("immediate data wrong");
  a_dir_page: assert property (@(posedge clock) disable iff (sys_rst)
    (finish && mode_q == OAG_DIR) |=> eff_addr[15:8] == 8'h00 && instr_len == 2'h2)
    else $error("direct high byte not zero");
  a_ix1_span: assert property (@(posedge clock) disable iff (sys_rst)
    addr_valid && $past(mode_q) == OAG_IX1 |-> eff_addr <= 16'h01FE)
    else $error("indexed 8-bit sum out of span");
  // three-byte forms: accepted start, then the low operand byte closes them
  sequence s_long_start;
    start && state_q == OAG_IDLE && (mode == OAG_EXT || mode == OAG_IX2);
  endsequence
  sequence s_low_byte;
    state_q == OAG_BYTE2 && byte_valid;
  endsequence
  a_long_wait: assert property (@(posedge clock) disable iff (sys_rst)
    s_long_start |=> busy && !done)
    else $error("three-byte start not waiting");
  a_three_len: assert property (@(posedge clock) disable iff (sys_rst)
    s_low_byte |=> done && instr_len == 2'h3 && !busy)
    else $error("three-byte length wrong");
  a_br_target: assert property (@(posedge clock) disable iff (sys_rst)
    (finish && mode_q == OAG_REL && !taken_q) |=> pc_load && pc_target == $past(pc_q))
    else $error("untaken branch moved");
endmodule

/* File: testbench/oag_mem_model.sv */
// operand byte source standing in for program memory
// assumes the bench queues each instruction's bytes before its start
`timescale 1ns/1ps
module oag_mem_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       busy,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] q[$];
  // ****************************************
  // byte delivery
  // ****************************************
  // random stalls; idle data inverts so a stale byte never passes as fresh
  // plain always: the bench fills the queue from its own process
  // back-to-back bytes are allowed so both operand bytes can arrive on adjacent edges
  always @(posedge clock) begin
    if (sys_rst) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else if (busy && q.size() > 0 && $urandom_range(1, 0) == 1) begin
      byte_valid <= 1'b1;
      byte_data  <= q.pop_front();
    end else begin
      byte_valid <= 1'b0;
      byte_data  <= ~byte_data;
    end
  end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the operand address generator
// assumes oag_mem_model feeds operand bytes in queue order
`timescale 1ns/1ps
module tb;
  import oag_pkg::*;
  logic        clock, sys_rst, start, branch_taken, byte_valid;
  logic        done, addr_valid, imm_valid, pc_load, mul_valid, busy;
  logic [1:0]  instr_len;
  logic [7:0]  acc_in, idx_in, byte_data, imm_data, acc_out, idx_out;
  logic [15:0] pc_next, eff_addr, pc_target;
  oag_mode_t   mode;
  int          failures, n_tests, cyc;

  oag_core u_oag_core (.clock(clock), .sys_rst(sys_rst), .start(start), .mode(mode),
    .branch_taken(branch_taken), .pc_next(pc_next), .acc_in(acc_in), .idx_in(idx_in),
    .byte_valid(byte_valid), .byte_data(byte_data), .done(done), .instr_len(instr_len),
    .addr_valid(addr_valid), .eff_addr(eff_addr), .imm_valid(imm_valid),
    .imm_data(imm_data), .pc_load(pc_load), .pc_target(pc_target),
    .mul_valid(mul_valid), .acc_out(acc_out), .idx_out(idx_out), .busy(busy));
  oag_mem_model u_oag_mem_model (.clock(clock), .sys_rst(sys_rst), .busy(busy),
    .byte_valid(byte_valid), .byte_data(byte_data));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ceiling well above 180 instructions of at most a few dozen cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    logic [7:0]  x, a, b0, b1;
    logic [15:0] ea, pt, pc;
    logic [1:0]  ln;
    logic        av, tk;
    oag_mode_t   m;
    int          w;
    sys_rst = 1'b1;
    start = 1'b0;
    mode = OAG_INH;
    branch_taken = 1'b0;
    pc_next = 16'h0000;
    acc_in = 8'h00;
    idx_in = 8'h00;
    w = $urandom(32'h0680);
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("instr_len", 16'h0001, 16'(instr_len));
    chk("done", 16'h0000, 16'(done));
    chk("busy", 16'h0000, 16'(busy));
    for (int i = 0; i < 180; i++) begin
      m = oag_mode_t'(i % 9);
      // first nine rows hit the top of the IX1 sum and the product; the next nine hit the most negative offset
      x = (i < 9) ? 8'hFF : 8'($urandom);
      a = (i < 9) ? 8'hFF : 8'($urandom);
      b0 = (i < 9) ? 8'hFF : (i < 18) ? 8'h80 : 8'($urandom);
      b1 = 8'($urandom);
      pc = 16'($urandom);
      tk = 1'($urandom);
      pt = tk ? pc + {{8{b0[7]}}, b0} : pc;
      case (m)
        OAG_DIR: ea = {8'h00, b0};
        OAG_EXT: ea = {b0, b1};
        OAG_IX0: ea = {8'h00, x};
        OAG_IX1: ea = 16'(x) + 16'(b0);
        default: ea = {b0, b1} + 16'(x);
      endcase
      av = m inside {OAG_DIR, OAG_EXT, OAG_IX0, OAG_IX1, OAG_IX2};
      ln = (m inside {OAG_EXT, OAG_IX2}) ? 2'h3 : (m inside {OAG_IMM, OAG_DIR, OAG_IX1,
        OAG_REL}) ? 2'h2 : 2'h1;
      if (ln > 2'h1) u_oag_mem_model.q.push_back(b0);
      if (ln > 2'h2) u_oag_mem_model.q.push_back(b1);
      @(posedge clock);
      start <= 1'b1;
      mode <= m;
      branch_taken <= tk;
      pc_next <= pc;
      acc_in <= a;
      idx_in <= x;
      @(posedge clock);
      // a second start while bytes are awaited must be ignored
      start <= (ln > 2'h1);
      mode <= OAG_INH;
      w = 0;
      #1;
      if (ln > 2'h1) chk("busy", 16'h0001, 16'(busy));
      while (done !== 1'b1 && w < 40) begin
        @(posedge clock);
        start <= 1'b0;
        #1;
        w++;
      end
      chk("done", 16'h0001, 16'(done));
      chk("instr_len", 16'(ln), 16'(instr_len));
      chk("busy", 16'h0000, 16'(busy));
      chk("addr_valid", 16'(av), 16'(addr_valid));
      if (av) chk("eff_addr", ea, eff_addr);
      chk("imm_valid", 16'(m == OAG_IMM), 16'(imm_valid));
      if (m == OAG_IMM) chk("imm_data", 16'(b0), 16'(imm_data));
      chk("pc_load", 16'(m == OAG_REL), 16'(pc_load));
      if (m == OAG_REL) chk("pc_target", pt, pc_target);
      chk("mul_valid", 16'(m == OAG_MUL), 16'(mul_valid));
      if (m == OAG_MUL) chk("product", 16'(a) * 16'(x), {idx_out, acc_out});
    end
    conclude();
  end
endmodule
